/* File: pau_cfg.svh */
// constants for the process alarm unit: offsets, field positions, reset values, timing
// assumes inclusion by bare name from the package and the top module
`ifndef PAU_CFG_SVH
`define PAU_CFG_SVH

// ----------------------------------------------------------------
// channel counts
// ----------------------------------------------------------------
`define PAU_BASE_CHANNELS 2
`define PAU_MAX_CHANNELS 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PAU_CLK_HZ 25000000
`define PAU_TICK_TIME_S 1
`define PAU_TIME_MAX 13'h1964

// ----------------------------------------------------------------
// register byte offsets and channel decode
// ----------------------------------------------------------------
`define PAU_OFS_CTRL 8'h00
`define PAU_OFS_STATUS 8'h04
`define PAU_OFS_PV 8'h08
`define PAU_CH_PAGE 2'h1
`define PAU_CH_MODE 2'h0
`define PAU_CH_SETPOINT 2'h1
`define PAU_CH_REFERENCE 2'h2
`define PAU_CH_TIMES 2'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PAU_ST_LED_LSB 0
`define PAU_ST_RELAY_LSB 4
`define PAU_ST_FITTED_BIT 8
`define PAU_ST_BREAK_BIT 9
`define PAU_TIMES_T2_LSB 16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PAU_RST_BLOCK 4'h0
`define PAU_RST_VALUE 16'h0000
`define PAU_RST_TIME 13'h0000

`endif

/* File: pau_pkg.sv */
// types shared by the process alarm unit modules
// assumes pau_cfg.svh is on the include path
`include "pau_cfg.svh"

`default_nettype none

package pau_pkg;

    // ----------------------------------------------------------------
    // modes and timer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        pau_disabled_mode = 3'b000,
        pau_sensor_break_mode = 3'b001,
        pau_under_setpoint_mode = 3'b010,
        pau_above_setpoint_mode = 3'b011,
        pau_deviation_low_mode = 3'b100,
        pau_deviation_high_mode = 3'b101,
        pau_band_outside_mode = 3'b110,
        pau_band_inside_mode = 3'b111
    } pau_mode_type;

    typedef enum logic [2:0] {
        pau_idle_st = 3'b000,
        pau_delay_st = 3'b001,
        pau_on_st = 3'b010,
        pau_off_st = 3'b011,
        pau_done_st = 3'b100
    } pau_timer_type;

    // ----------------------------------------------------------------
    // module state records
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] count;
        logic tick;
    } pau_tick_state_type;

    typedef struct packed {
        pau_timer_type fsm;
        logic [12:0] cnt;
        logic blocked;
        logic cond;
        logic relay;
    } pau_chan_state_type;

    typedef struct packed {
        logic [3:0] block_en;
        pau_mode_type [3:0] mode;
        logic [3:0][15:0] setpoint;
        logic [3:0][15:0] reference;
        logic [3:0][12:0] t1;
        logic [3:0][12:0] t2;
        logic [15:0] pv;
        logic brk;
        logic fitted;
        logic strap_done;
        logic waitreq;
        logic [31:0] rdata;
    } pau_top_state_type;

endpackage

`default_nettype wire

/* File: pau_tick.sv */
// one-second enable divider for the alarm timers
// assumes i_clk free running; o_tick is a one-cycle pulse every TICK_CYCLES cycles
`timescale 1ns/1ns
`default_nettype none

module pau_tick #(
    parameter int unsigned TICK_CYCLES = 25000000
) (
    input wire logic i_clk,
    input wire logic i_rst,
    output logic o_tick
);
    import pau_pkg::*;

    pau_tick_state_type s_q;
    pau_tick_state_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.count == TICK_CYCLES - 32'd1)
        begin
            s_d.count = 32'd0;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.count = s_q.count + 32'd1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;
endmodule // pau_tick

`default_nettype wire

/* File: pau_chan.sv */
// one alarm channel: comparison, initial blocking and relay timer
// assumes i_pv_valid pulses once per new process value and i_tick pulses once a second
`timescale 1ns/1ns
`default_nettype none

module pau_chan (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_pv_valid,
    input wire logic [15:0] i_process_value,
    input wire logic i_sensor_break,
    input wire pau_pkg::pau_mode_type i_mode,
    input wire logic [15:0] i_alarm_setpoint_value,
    input wire logic [15:0] i_alarm_reference_value,
    input wire logic [12:0] i_first_timer_time,
    input wire logic [12:0] i_second_timer_time,
    input wire logic i_block_en,
    output logic o_led,
    output logic o_relay
);
    import pau_pkg::*;

    function automatic logic signed [17:0] sx(input logic [15:0] v);
        sx = {{2{v[15]}}, v};
    endfunction

    pau_chan_state_type s_q;
    pau_chan_state_type s_d;
    logic signed [17:0] pv;
    logic signed [17:0] sp;
    logic signed [17:0] rf;
    logic signed [17:0] diff;
    logic signed [17:0] mag;
    logic raw;
    logic eval;
    logic [12:0] cnt_inc;

    always_comb
    begin
        pv = sx(i_process_value);
        sp = sx(i_alarm_setpoint_value);
        rf = sx(i_alarm_reference_value);
        diff = pv - rf;
        mag = diff[17] ? -diff : diff;
        cnt_inc = s_q.cnt + 13'h0001;
        s_d = s_q;
        // ----------------------------------------------------------------
        // comparison
        // ----------------------------------------------------------------
        case (i_mode)
            pau_disabled_mode: raw = 1'b0;
            pau_sensor_break_mode: raw = i_sensor_break;
            pau_under_setpoint_mode: raw = pv < sp;
            pau_above_setpoint_mode: raw = pv > sp;
            pau_deviation_low_mode: raw = pv < rf - sp;
            pau_deviation_high_mode: raw = pv > rf + sp;
            pau_band_outside_mode: raw = mag > sp;
            pau_band_inside_mode: raw = mag < sp;
            default: raw = 1'b0;
        endcase
        eval = i_pv_valid || i_mode == pau_sensor_break_mode || i_mode == pau_disabled_mode;
        if (eval)
        begin
            if (!raw && i_mode != pau_disabled_mode)
            begin
                s_d.blocked = 1'b0;
            end
            s_d.cond = raw && !(s_q.blocked && i_block_en && i_mode != pau_sensor_break_mode);
        end
        // ----------------------------------------------------------------
        // relay timer
        // ----------------------------------------------------------------
        case (s_q.fsm)
            pau_idle_st:
            begin
                s_d.cnt = 13'h0000;
                if (s_q.cond)
                begin
                    if (i_first_timer_time == 13'h0000 && i_second_timer_time != 13'h0000)
                    begin
                        s_d.fsm = pau_delay_st;
                    end
                    else
                    begin
                        s_d.fsm = pau_on_st;
                    end
                end
            end
            pau_delay_st:
            begin
                if (i_tick)
                begin
                    s_d.cnt = cnt_inc;
                    if (cnt_inc == i_second_timer_time)
                    begin
                        s_d.fsm = pau_on_st;
                        s_d.cnt = 13'h0000;
                    end
                end
            end
            pau_on_st:
            begin
                if (i_tick && i_first_timer_time != 13'h0000)
                begin
                    s_d.cnt = cnt_inc;
                    if (cnt_inc == i_first_timer_time)
                    begin
                        s_d.cnt = 13'h0000;
                        s_d.fsm = (i_second_timer_time == 13'h0000) ? pau_done_st : pau_off_st;
                    end
                end
            end
            pau_off_st:
            begin
                if (i_tick)
                begin
                    s_d.cnt = cnt_inc;
                    if (cnt_inc == i_second_timer_time)
                    begin
                        s_d.cnt = 13'h0000;
                        s_d.fsm = pau_on_st;
                    end
                end
            end
            pau_done_st: s_d.fsm = pau_done_st;
            default: s_d.fsm = pau_idle_st;
        endcase
        if (!s_q.cond)
        begin
            s_d.fsm = pau_idle_st;
            s_d.cnt = 13'h0000;
        end
        s_d.relay = s_d.fsm == pau_on_st;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q <= '0;
            s_q.fsm <= pau_idle_st;
            s_q.blocked <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_led = s_q.cond;
    assign o_relay = s_q.relay;
endmodule // pau_chan

`default_nettype wire

/* File: pau_top.sv */
// process alarm unit: register slave, tick divider and four alarm channels
// assumes an Avalon-MM master on i_clk; process value and break flag synchronous to i_clk
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pau_cfg.svh"

module pau_top #(
    parameter int unsigned TICK_CYCLES = `PAU_TICK_TIME_S * `PAU_CLK_HZ
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_pv_valid,
    input wire logic [15:0] i_process_value,
    input wire logic i_sensor_break,
    input wire logic i_extra_outputs_fitted,
    output logic [3:0] o_alarm_led,
    output logic [3:0] o_alarm_relay
);
    import pau_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic [12:0] sat_time(input logic [15:0] v);
        sat_time = (v > {3'h0, `PAU_TIME_MAX}) ? `PAU_TIME_MAX : v[12:0];
    endfunction

    pau_top_state_type s_q;
    pau_top_state_type s_d;
    logic tick;
    logic [3:0] led;
    logic [3:0] relay;
    logic req;
    logic hit_ch;
    logic [1:0] ch;
    logic [1:0] reg_sel;
    logic [31:0] rd;
    logic [31:0] wv;
    pau_mode_type [3:0] eff_mode;

    // ----------------------------------------------------------------
    // one-second tick
    // ----------------------------------------------------------------
    pau_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    // ----------------------------------------------------------------
    // alarm channels
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < `PAU_MAX_CHANNELS; i++)
        begin
            eff_mode[i] = (s_q.fitted || i < `PAU_BASE_CHANNELS) ? s_q.mode[i] : pau_disabled_mode;
        end
    end

    for (genvar g = 0; g < `PAU_MAX_CHANNELS; g++)
    begin : g_chan
        pau_chan u_chan (
            .i_clk(i_clk),
            .i_rst(i_rst),
            .i_tick(tick),
            .i_pv_valid(i_pv_valid),
            .i_process_value(i_process_value),
            .i_sensor_break(i_sensor_break),
            .i_mode(eff_mode[g]),
            .i_alarm_setpoint_value(s_q.setpoint[g]),
            .i_alarm_reference_value(s_q.reference[g]),
            .i_first_timer_time(s_q.t1[g]),
            .i_second_timer_time(s_q.t2[g]),
            .i_block_en(s_q.block_en[g]),
            .o_led(led[g]),
            .o_relay(relay[g])
        );
    end

    // ----------------------------------------------------------------
    // register slave
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        req = i_avs_read || i_avs_write;
        hit_ch = i_avs_address[7:6] == `PAU_CH_PAGE;
        ch = i_avs_address[5:4];
        reg_sel = i_avs_address[3:2];
        rd = 32'h0000_0000;
        if (!s_q.strap_done)
        begin
            s_d.fitted = i_extra_outputs_fitted;
            s_d.strap_done = 1'b1;
        end
        if (i_pv_valid)
        begin
            s_d.pv = i_process_value;
        end
        s_d.brk = i_sensor_break;
        if (hit_ch)
        begin
            case (reg_sel)
                `PAU_CH_MODE: rd[2:0] = s_q.mode[ch];
                `PAU_CH_SETPOINT: rd[15:0] = s_q.setpoint[ch];
                `PAU_CH_REFERENCE: rd[15:0] = s_q.reference[ch];
                `PAU_CH_TIMES:
                begin
                    rd[12:0] = s_q.t1[ch];
                    rd[`PAU_TIMES_T2_LSB +: 13] = s_q.t2[ch];
                end
                default: rd = 32'h0000_0000;
            endcase
        end
        else
        begin
            case (i_avs_address)
                `PAU_OFS_CTRL: rd[3:0] = s_q.block_en;
                `PAU_OFS_STATUS:
                begin
                    rd[`PAU_ST_LED_LSB +: 4] = led;
                    rd[`PAU_ST_RELAY_LSB +: 4] = relay;
                    rd[`PAU_ST_FITTED_BIT] = s_q.fitted;
                    rd[`PAU_ST_BREAK_BIT] = s_q.brk;
                end
                `PAU_OFS_PV: rd[15:0] = s_q.pv;
                default: rd = 32'h0000_0000;
            endcase
        end
        wv = merge(rd, i_avs_writedata, i_avs_byteenable);
        // one wait state: answer at the second edge of each request
        s_d.waitreq = !(req && s_q.waitreq);
        if (req && s_q.waitreq)
        begin
            s_d.rdata = i_avs_read ? rd : 32'h0000_0000;
        end
        if (i_avs_write && !s_q.waitreq)
        begin
            if (hit_ch)
            begin
                case (reg_sel)
                    `PAU_CH_MODE: s_d.mode[ch] = pau_mode_type'(wv[2:0]);
                    `PAU_CH_SETPOINT: s_d.setpoint[ch] = wv[15:0];
                    `PAU_CH_REFERENCE: s_d.reference[ch] = wv[15:0];
                    `PAU_CH_TIMES:
                    begin
                        s_d.t1[ch] = sat_time(wv[15:0]);
                        s_d.t2[ch] = sat_time(wv[`PAU_TIMES_T2_LSB +: 16]);
                    end
                    default: s_d.mode[ch] = s_q.mode[ch];
                endcase
            end
            else if (i_avs_address == `PAU_OFS_CTRL)
            begin
                s_d.block_en = wv[3:0];
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q.block_en <= `PAU_RST_BLOCK;
            for (int i = 0; i < `PAU_MAX_CHANNELS; i++)
            begin
                s_q.mode[i] <= pau_disabled_mode;
                s_q.setpoint[i] <= `PAU_RST_VALUE;
                s_q.reference[i] <= `PAU_RST_VALUE;
                s_q.t1[i] <= `PAU_RST_TIME;
                s_q.t2[i] <= `PAU_RST_TIME;
            end
            s_q.pv <= `PAU_RST_VALUE;
            s_q.brk <= 1'b0;
            s_q.fitted <= 1'b0;
            s_q.strap_done <= 1'b0;
            s_q.waitreq <= 1'b1;
            s_q.rdata <= 32'h0000_0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_avs_readdata = s_q.rdata;
    assign o_avs_waitrequest = s_q.waitreq;
    assign o_alarm_led = led;
    assign o_alarm_relay = relay;
endmodule // pau_top

`default_nettype wire

/* File: pau_top_sva.sv */
// assertion checker for the process alarm unit top ports
// assumes bus writes use full byte lanes on channel 0 registers
`timescale 1ns/1ns
`default_nettype none

module pau_top_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_pv_valid,
    input wire logic [15:0] i_process_value,
    input wire logic i_sensor_break,
    input wire logic i_extra_outputs_fitted,
    input wire logic [3:0] o_alarm_led,
    input wire logic [3:0] o_alarm_relay
);
    import pau_pkg::*;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // ----
    // channel 0 settings snooped from the bus
    // ----
    pau_mode_type mode_q;
    logic [15:0] sp_q;
    logic [15:0] ref_q;
    logic tz_q;
    logic signed [17:0] pv_s;
    logic signed [17:0] sp_s;
    logic signed [17:0] lo_s;
    logic signed [17:0] hi_s;
    logic exp_led;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            mode_q <= pau_disabled_mode;
            sp_q <= 16'h0000;
            ref_q <= 16'h0000;
            tz_q <= 1'b1;
        end
        else if (i_avs_write && !o_avs_waitrequest && i_avs_address[7:4] == 4'h4)
        begin
            case (i_avs_address[3:2])
                2'h0: mode_q <= pau_mode_type'(i_avs_writedata[2:0]);
                2'h1: sp_q <= i_avs_writedata[15:0];
                2'h2: ref_q <= i_avs_writedata[15:0];
                default: tz_q <= (i_avs_writedata == 32'h00000000);
            endcase
        end
    end

    always_comb
    begin
        pv_s = $signed(i_process_value);
        sp_s = $signed(sp_q);
        lo_s = $signed(ref_q) - sp_s;
        hi_s = $signed(ref_q) + sp_s;
        case (mode_q)
            pau_under_setpoint_mode: exp_led = pv_s < sp_s;
            pau_above_setpoint_mode: exp_led = pv_s > sp_s;
            pau_deviation_low_mode: exp_led = pv_s < lo_s;
            pau_deviation_high_mode: exp_led = pv_s > hi_s;
            pau_band_outside_mode: exp_led = (pv_s < lo_s) || (pv_s > hi_s);
            pau_band_inside_mode: exp_led = (pv_s > lo_s) && (pv_s < hi_s);
            default: exp_led = 1'b0;
        endcase
    end

    // ----
    // assertions
    // ----
    AST_WAIT_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("no answer one cycle after request");
    AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_WAIT_IDLE: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("answer without request");
    AST_WRITE_ZERO: assert property (!o_avs_waitrequest && i_avs_write |-> o_avs_readdata == 32'h00000000)
        else $error("write answer carries data");
    AST_RELAY_OFF: assert property (1'b1 |=> (o_alarm_relay & ~$past(o_alarm_led)) == 4'h0)
        else $error("relay on without alarm");
    AST_BREAK: assert property (mode_q == pau_sensor_break_mode |=> o_alarm_led[0] == $past(i_sensor_break))
        else $error("break indicator wrong");
    AST_DISABLED: assert property (mode_q == pau_disabled_mode |=> !o_alarm_led[0])
        else $error("disabled channel active");
    AST_COMPARE: assert property (mode_q[2:1] != 2'b00 && i_pv_valid |=> o_alarm_led[0] == $past(exp_led))
        else $error("compare result wrong");
    AST_BYPASS: assert property (tz_q |=> o_alarm_relay[0] == $past(o_alarm_led[0]))
        else $error("relay not following alarm");
endmodule // pau_top_sva

bind pau_top pau_top_sva u_sva (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_pv_valid(i_pv_valid),
    .i_process_value(i_process_value), .i_sensor_break(i_sensor_break),
    .i_extra_outputs_fitted(i_extra_outputs_fitted), .o_alarm_led(o_alarm_led), .o_alarm_relay(o_alarm_relay)
);

`default_nettype wire

/* File: pau_meas_model.sv */
// measurement front end model: value pulses and sensor break level
// assumes the caller runs its tasks from one process on i_clk
`timescale 1ns/1ns
`default_nettype none

module pau_meas_model (
    input wire logic i_clk,
    output logic o_pv_valid,
    output logic [15:0] o_process_value,
    output logic o_sensor_break
);
    initial
    begin
        o_pv_valid = 1'b0;
        o_process_value = 16'h0000;
        o_sensor_break = 1'b0;
    end

    // one value pulse; data turned over once the pulse is gone
    task automatic send(input logic [15:0] v);
        @(posedge i_clk);
        o_pv_valid <= 1'b1;
        o_process_value <= v;
        @(posedge i_clk);
        o_pv_valid <= 1'b0;
        o_process_value <= ~v;
    endtask

    task automatic set_break(input logic b);
        @(posedge i_clk);
        o_sensor_break <= b;
    endtask
endmodule // pau_meas_model

`default_nettype wire

/* File: tb_pau_top.sv */
// self-checking bench for the process alarm unit
// assumes a tick of 10 cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); end end

module tb_pau_top;
    import pau_pkg::*;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] avs_addr = 8'h00;
    logic avs_rd = 1'b0;
    logic avs_wr = 1'b0;
    logic [31:0] avs_wd = 32'h00000000;
    logic [3:0] avs_be = 4'h0;
    logic fitted = 1'b1;
    logic [3:0] be_sel = 4'hf;
    logic [31:0] rdat;
    logic [31:0] o_avs_readdata;
    logic o_avs_waitrequest;
    logic pv_valid;
    logic [15:0] pv;
    logic brk;
    logic [3:0] o_alarm_led;
    logic [3:0] o_alarm_relay;
    int num_errors = 0;
    int total_checks = 0;
    logic [15:0] pvs [10] = '{16'd9, 16'd10, 16'd11, 16'd89, 16'd90, 16'd91, 16'd109, 16'd110, 16'd111, 16'hff38};

    always #20 i_clk = ~i_clk;

    pau_top #(.TICK_CYCLES(10)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr),
        .i_avs_writedata(avs_wd), .i_avs_byteenable(avs_be), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_pv_valid(pv_valid), .i_process_value(pv),
        .i_sensor_break(brk), .i_extra_outputs_fitted(fitted), .o_alarm_led(o_alarm_led), .o_alarm_relay(o_alarm_relay)
    );

    pau_meas_model u_meas (.i_clk(i_clk), .o_pv_valid(pv_valid), .o_process_value(pv), .o_sensor_break(brk));

    // ----
    // bus and wait helpers
    // ----
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
        @(posedge i_clk);
        avs_rd <= !w;
        avs_wr <= w;
        avs_addr <= a;
        avs_wd <= wd;
        avs_be <= be_sel;
        do
            @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0);
        d = o_avs_readdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask

    task automatic wait_relay(input logic lvl, output int n);
        n = 0;
        while (o_alarm_relay[0] !== lvl && n <= 200)
        begin
            @(posedge i_clk);
            n++;
        end
    endtask

    function automatic logic exp_cmp(input int m, input int v);
        case (m)
            2: return v < 10;
            3: return v > 10;
            4: return v < 90;
            5: return v > 110;
            6: return v < 90 || v > 110;
            7: return v > 90 && v < 110;
            default: return 1'b0;
        endcase
    endfunction

    // ----
    // scenarios
    // ----
    task automatic t_regs;
        bus(1'b0, 8'h40, 32'h0, rdat);
        `CHK(rdat, 32'h00000000)
        bus(1'b1, 8'h5c, 32'hffffffff, rdat);
        bus(1'b0, 8'h5f, 32'h0, rdat);
        `CHK(rdat, 32'h19641964)
        be_sel = 4'h2;
        bus(1'b1, 8'h58, 32'hffffffff, rdat);
        be_sel = 4'hf;
        bus(1'b0, 8'h58, 32'h0, rdat);
        `CHK(rdat, 32'h0000ff00)
        bus(1'b1, 8'h04, 32'hffffffff, rdat);
        bus(1'b1, 8'h20, 32'hffffffff, rdat);
        bus(1'b0, 8'h04, 32'h0, rdat);
        `CHK(rdat, 32'h00000100)
        bus(1'b0, 8'h20, 32'h0, rdat);
        `CHK(rdat, 32'h00000000)
    endtask

    task automatic t_compare;
        bus(1'b1, 8'h44, 32'd10, rdat);
        bus(1'b1, 8'h48, 32'd100, rdat);
        for (int m = 2; m < 8; m++)
        begin
            bus(1'b1, 8'h40, 32'(m), rdat);
            foreach (pvs[i])
            begin
                u_meas.send(pvs[i]);
                repeat (2) @(posedge i_clk);
                `CHK(o_alarm_led[0], exp_cmp(m, $signed(pvs[i])))
                `CHK(o_alarm_relay[0], exp_cmp(m, $signed(pvs[i])))
            end
        end
    endtask

    task automatic t_break;
        bus(1'b1, 8'h00, 32'h4, rdat);
        bus(1'b1, 8'h40, 32'h1, rdat);
        bus(1'b1, 8'h60, 32'h1, rdat);
        u_meas.set_break(1'b1);
        repeat (3) @(posedge i_clk);
        `CHK(o_alarm_led, 4'h5)
        bus(1'b0, 8'h04, 32'h0, rdat);
        `CHK(rdat, 32'h00000355)
        bus(1'b1, 8'h40, 32'h0, rdat);
        repeat (3) @(posedge i_clk);
        `CHK(o_alarm_led, 4'h4)
        u_meas.set_break(1'b0);
        repeat (3) @(posedge i_clk);
        `CHK(o_alarm_led, 4'h0)
        bus(1'b1, 8'h60, 32'h0, rdat);
    endtask

    task automatic t_timers;
        int n;
        bus(1'b1, 8'h44, 32'd50, rdat);
        bus(1'b1, 8'h40, 32'h2, rdat);
        u_meas.send(16'd100);
        bus(1'b1, 8'h4c, 32'h00030000, rdat);
        u_meas.send(16'd10);
        wait_relay(1'b1, n);
        `CHK(n inside {[18:33]}, 1'b1)
        u_meas.send(16'd100);
        repeat (3) @(posedge i_clk);
        `CHK(o_alarm_relay[0], 1'b0)
        bus(1'b1, 8'h4c, 32'h00000002, rdat);
        u_meas.send(16'd10);
        wait_relay(1'b1, n);
        `CHK(n <= 3, 1'b1)
        wait_relay(1'b0, n);
        `CHK(n inside {[9:21]}, 1'b1)
        wait_relay(1'b1, n);
        `CHK(n > 200, 1'b1)
        u_meas.send(16'd100);
        bus(1'b1, 8'h4c, 32'h00030002, rdat);
        u_meas.send(16'd10);
        wait_relay(1'b1, n);
        `CHK(n <= 3, 1'b1)
        wait_relay(1'b0, n);
        wait_relay(1'b1, n);
        `CHK(n, 30)
        wait_relay(1'b0, n);
        `CHK(n, 20)
        u_meas.send(16'd100);
        u_meas.send(16'd10);
        wait_relay(1'b1, n);
        `CHK(n <= 3, 1'b1)
        u_meas.send(16'd100);
        repeat (3) @(posedge i_clk);
        `CHK(o_alarm_relay[0], 1'b0)
        bus(1'b1, 8'h40, 32'h0, rdat);
    endtask

    task automatic t_reset;
        fitted <= 1'b0;
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(1'b1, 8'h00, 32'h2, rdat);
        bus(1'b1, 8'h54, 32'd50, rdat);
        bus(1'b1, 8'h50, 32'h2, rdat);
        bus(1'b1, 8'h60, 32'h1, rdat);
        u_meas.set_break(1'b1);
        u_meas.send(16'd10);
        @(posedge i_clk);
        `CHK(o_alarm_led, 4'h0)
        u_meas.send(16'd100);
        u_meas.send(16'd10);
        @(posedge i_clk);
        `CHK(o_alarm_led, 4'h2)
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_compare();
        t_break();
        t_timers();
        t_reset();
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        summarize();
    end
endmodule // tb_pau_top

`default_nettype wire
